// ===== rtl/pmc_regs.vh
// Constants for the transceiver miscellaneous control register bank.
// Included by the bank and its phase stepper; definitions only.
`ifndef PMC_REGS_VH
`define PMC_REGS_VH
`define PMC_IDX_TXCPS 9'h042
`define PMC_IDX_PBO 9'h0ae
`define PMC_IDX_VRC 9'h0d0
`define PMC_IDX_CLD 9'h155
`define PMC_IDX_CDS 9'h170
`define PMC_PHASE_MOD 4'ha
`define PMC_PHASE_STEP_NS 4
`define PMC_CLK_NS 40
`define PMC_PBO_RESET 3'h0
`define PMC_PBO_RO_VAL 16'h8020
`define PMC_AVG_RESET 3'h1
`define PMC_CDS_AVG_RESET 3'h6
`define PMC_CDS_RSV11 16'h0800
`define PMC_BIT_PSEN 4
`define PMC_BIT_REGULATOR_POWER_DOWN 15
`define PMC_BIT_START 15
`define PMC_BIT_CROSS 14
`define PMC_BIT_TXBYP 13
`define PMC_BIT_RXBYP 12
`define PMC_BIT_RSV11 11
`endif

// ===== rtl/pmc_phase_step.v
// Phase stepper: moves the applied transmit clock phase toward a target.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
`include "pmc_regs.vh"
module pmc_phase_step (
  // Clock and reset.
  input wire ref_clk_i,
  input wire reset_i,
  // Request.
  input wire start_i,
  input wire [3:0] target_i,
  // State.
  output reg [3:0] phase_o,
  output reg busy_o,
  output reg step_pulse_o,
  output reg step_dir_o
);
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      phase_o <= 4'h0;
      busy_o <= 1'b0;
      step_pulse_o <= 1'b0;
      step_dir_o <= 1'b0;
    end else begin
      step_pulse_o <= 1'b0;
      if (start_i && !busy_o && target_i != phase_o) begin
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (target_i == phase_o) begin
          busy_o <= 1'b0;
        end else begin
          step_pulse_o <= 1'b1;
          step_dir_o <= (target_i > phase_o);
          phase_o <= (target_i > phase_o) ? phase_o + 4'h1 : phase_o - 4'h1;
        end
      end
    end
  end
endmodule // pmc_phase_step
`default_nettype wire

// ===== rtl/pmc_regbank.v
// Miscellaneous transceiver control register bank behind an APB slave.
// Assumes a 25 MHz clock, synchronous reset, APB master holding requests.
//
// Contract
// - Phase field reports current transmit clock offset in 4 ns steps.
// - New phase moves the clock by 4 ns times the value difference.
// - Written phase above ten is reduced modulo ten.
// - Phase enable bit 4 triggers the shift and clears itself.
// - Phase register bits 15 to 5 ignore writes and read zero.
// - Power back off bits 8 to 6 select normal or levels one to three.
// - Regulator power-down bit 15 powers down regulator and self-clears.
// - Cable-length averaging factor bits 2 to 0, reset 001.
// - Bit 12 read-only transmit pair bypass skips reflectometry when set.
// - Cross-disable bit 14 selects regular-only reflectometry.
// - Averaging bits 10 to 8 select 1 to 64 cycles; 111 reserved.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "pmc_regs.vh"
module pmc_regbank (
  // Clock and reset.
  input wire ref_clk_i,
  input wire reset_i,
  // APB slave.
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Phase control.
  output reg [3:0] tx_clock_phase_o,
  output reg phase_busy_o,
  output reg phase_step_o,
  output reg phase_step_up_o,
  // Power and regulator.
  output reg [2:0] power_backoff_level_o,
  output reg regulator_power_down_o,
  output reg [3:0] regulator_control_o,
  // Cable diagnostics.
  output reg cable_length_start_o,
  output reg [2:0] cable_length_avg_o,
  output reg tdr_cross_disable_o,
  output reg transmit_pair_bypass_o,
  output reg [2:0] tdr_avg_code_o,
  output reg [6:0] tdr_avg_cycles_o,
  input wire cable_length_valid_i,
  input wire [7:0] cable_length_result_i,
  input wire transmit_pair_bypass_i
);
  localparam ST_IDLE = 1'b0;
  localparam ST_DONE = 1'b1;

  reg state;
  reg [3:0] phase_target;
  reg phase_start;
  reg [2:0] pbo;
  reg vr_pd;
  reg [10:0] vr_rsv;
  reg [3:0] vr_ctl;
  reg [2:0] cl_avg;
  reg [7:0] cl_result;
  reg cl_bypass;
  reg cds_cross;
  reg cds_txbyp;
  reg cds_rsv11;
  reg [2:0] cds_avg;
  reg [31:0] next_rdata;
  reg next_err;
  wire [3:0] applied_phase;
  wire step_busy;
  wire step_pulse;
  wire step_dir;
  wire wr_en;
  wire [8:0] idx;

  // Maps an averaging code to the number of reflectometry cycles.
  function [6:0] avg_cycles;
    input [2:0] code;
    begin
      if (code == 3'h7) begin
        avg_cycles = 7'h00;
      end else begin
        avg_cycles = 7'h01 << code;
      end
    end
  endfunction

  // Decodes whether a register index is mapped.
  function is_mapped;
    input [8:0] i;
    begin
      is_mapped = (i == `PMC_IDX_TXCPS) || (i == `PMC_IDX_PBO) || (i == `PMC_IDX_VRC) ||
        (i == `PMC_IDX_CLD) || (i == `PMC_IDX_CDS);
    end
  endfunction

  // Reduces a written phase into the legal range.
  function [3:0] phase_fold;
    input [3:0] v;
    begin
      phase_fold = (v > `PMC_PHASE_MOD) ? v % `PMC_PHASE_MOD : v;
    end
  endfunction

  assign idx = paddr_i[10:2];
  // A write lands at the edge where the master sees pready high, not before.
  assign wr_en = psel_i && penable_i && pwrite_i && (state == ST_DONE) && (paddr_i[11] == 1'b0) &&
    (paddr_i[1:0] == 2'h0) && is_mapped(idx);

  pmc_phase_step u_step (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .start_i(phase_start),
    .target_i(phase_target),
    .phase_o(applied_phase),
    .busy_o(step_busy),
    .step_pulse_o(step_pulse),
    .step_dir_o(step_dir)
  );

  // Read data mux and error decode.
  always @* begin
    next_rdata = 32'h0;
    next_err = (paddr_i[11] != 1'b0) || (paddr_i[1:0] != 2'h0) || !is_mapped(idx);
    case (idx)
      `PMC_IDX_TXCPS: begin
        next_rdata[3:0] = applied_phase;
      end
      `PMC_IDX_PBO: begin
        next_rdata[15:0] = `PMC_PBO_RO_VAL | {7'h0, pbo, 6'h0};
      end
      `PMC_IDX_VRC: begin
        next_rdata[15:0] = {vr_pd, vr_rsv, vr_ctl};
      end
      `PMC_IDX_CLD: begin
        next_rdata[15:0] = {1'b0, 2'h0, cl_bypass, cl_result, 1'b0, cl_avg};
      end
      `PMC_IDX_CDS: begin
        next_rdata[15:0] = {1'b0, cds_cross, cds_txbyp, transmit_pair_bypass_i, cds_rsv11,
          cds_avg, 8'h0};
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  // APB handshake: answer one cycle after the access phase starts.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          pready_o <= 1'b0;
          pslverr_o <= 1'b0;
          if (psel_i && penable_i) begin
            state <= ST_DONE;
            pready_o <= 1'b1;
            pslverr_o <= next_err;
            prdata_o <= pwrite_i ? 32'h0 : next_rdata;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
          pready_o <= 1'b0;
          pslverr_o <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Register writes and self-clearing controls.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      phase_target <= 4'h0;
      phase_start <= 1'b0;
      pbo <= `PMC_PBO_RESET;
      vr_pd <= 1'b0;
      vr_rsv <= 11'h0;
      vr_ctl <= 4'h0;
      cl_avg <= `PMC_AVG_RESET;
      cl_result <= 8'h0;
      cl_bypass <= 1'b0;
      cds_cross <= 1'b0;
      cds_txbyp <= 1'b0;
      cds_rsv11 <= 1'b1;
      cds_avg <= `PMC_CDS_AVG_RESET;
      cable_length_start_o <= 1'b0;
      regulator_power_down_o <= 1'b0;
    end else begin
      phase_start <= 1'b0;
      cable_length_start_o <= 1'b0;
      vr_pd <= 1'b0;
      regulator_power_down_o <= 1'b0;
      cl_bypass <= transmit_pair_bypass_i;
      if (cable_length_valid_i) begin
        cl_result <= cable_length_result_i;
      end
      if (wr_en) begin
        case (idx)
          `PMC_IDX_TXCPS: begin
            if (pwdata_i[`PMC_BIT_PSEN]) begin
              phase_target <= phase_fold(pwdata_i[3:0]);
              phase_start <= 1'b1;
            end
          end
          `PMC_IDX_PBO: begin
            pbo <= pwdata_i[8:6];
          end
          `PMC_IDX_VRC: begin
            vr_pd <= pwdata_i[`PMC_BIT_REGULATOR_POWER_DOWN];
            regulator_power_down_o <= pwdata_i[`PMC_BIT_REGULATOR_POWER_DOWN];
            vr_rsv <= pwdata_i[14:4];
            vr_ctl <= pwdata_i[3:0];
          end
          `PMC_IDX_CLD: begin
            cl_avg <= pwdata_i[2:0];
            cable_length_start_o <= pwdata_i[`PMC_BIT_START];
          end
          `PMC_IDX_CDS: begin
            cds_cross <= pwdata_i[`PMC_BIT_CROSS];
            cds_txbyp <= pwdata_i[`PMC_BIT_TXBYP];
            cds_rsv11 <= pwdata_i[`PMC_BIT_RSV11];
            cds_avg <= pwdata_i[10:8];
          end
          default: begin
            pbo <= pbo;
          end
        endcase
      end
    end
  end

  // Registered copies of control state for the analog side.
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_clock_phase_o <= 4'h0;
      phase_busy_o <= 1'b0;
      phase_step_o <= 1'b0;
      phase_step_up_o <= 1'b0;
      power_backoff_level_o <= `PMC_PBO_RESET;
      regulator_control_o <= 4'h0;
      cable_length_avg_o <= `PMC_AVG_RESET;
      tdr_cross_disable_o <= 1'b0;
      transmit_pair_bypass_o <= 1'b0;
      tdr_avg_code_o <= `PMC_CDS_AVG_RESET;
      tdr_avg_cycles_o <= 7'h40;
    end else begin
      tx_clock_phase_o <= applied_phase;
      phase_busy_o <= step_busy || phase_start;
      phase_step_o <= step_pulse;
      phase_step_up_o <= step_dir;
      power_backoff_level_o <= pbo;
      regulator_control_o <= vr_ctl;
      cable_length_avg_o <= cl_avg;
      tdr_cross_disable_o <= cds_cross;
      transmit_pair_bypass_o <= cds_txbyp;
      tdr_avg_code_o <= cds_avg;
      tdr_avg_cycles_o <= avg_cycles(cds_avg);
    end
  end
endmodule // pmc_regbank
`default_nettype wire

// ===== verif/pmc_regbank_chk.sv
// Checker for the control register bank.
// Bound to every bank instance; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module pmc_regbank_chk (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // APB.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  // Controls.
  input wire logic [3:0] tx_clock_phase_o,
  input wire logic phase_busy_o,
  input wire logic [2:0] power_backoff_level_o,
  input wire logic regulator_power_down_o,
  input wire logic cable_length_start_o,
  input wire logic [2:0] cable_length_avg_o,
  input wire logic [2:0] tdr_avg_code_o,
  input wire logic tdr_cross_disable_o,
  input wire logic [6:0] tdr_avg_cycles_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_range; tx_clock_phase_o <= 4'ha; endproperty
  a_range: assert property (p_range) else $error("phase above ten");
  property p_hold;
    psel_i && penable_i && pwrite_i && paddr_i == 12'h108 && !pwdata_i[4] && !phase_busy_o
      |=> $stable(tx_clock_phase_o) [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("phase moved without enable");
  property p_rsv; pready_o && psel_i && !pwrite_i && paddr_i == 12'h108 |-> prdata_o[31:4] == 0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("phase upper bits set");
  property p_bo;
    pready_o && psel_i && pwrite_i && paddr_i == 12'h2b8
      |-> ##2 power_backoff_level_o == $past(pwdata_i[8:6], 2);
  endproperty
  a_bo: assert property (p_bo) else $error("backoff level wrong");
  property p_vr; regulator_power_down_o |=> !regulator_power_down_o; endproperty
  a_vr: assert property (p_vr) else $error("power down not cleared");
  property p_pd;
    pready_o && psel_i && pwrite_i && paddr_i == 12'h340
      |=> regulator_power_down_o == $past(pwdata_i[15]);
  endproperty
  a_pd: assert property (p_pd) else $error("power down pulse wrong");
  property p_go;
    pready_o && psel_i && pwrite_i && paddr_i == 12'h554
      |=> cable_length_start_o == $past(pwdata_i[15]);
  endproperty
  a_go: assert property (p_go) else $error("start pulse wrong");
  property p_cross;
    pready_o && psel_i && pwrite_i && paddr_i == 12'h5c0
      |-> ##2 tdr_cross_disable_o == $past(pwdata_i[14], 2);
  endproperty
  a_cross: assert property (p_cross) else $error("cross disable wrong");
  property p_avg; $fell(reset_i) |-> cable_length_avg_o == 3'h1; endproperty
  a_avg: assert property (p_avg) else $error("averaging reset wrong");
  property p_start; cable_length_start_o |=> !cable_length_start_o; endproperty
  a_start: assert property (p_start) else $error("start not cleared");
  property p_cyc;
    $stable(tdr_avg_code_o)
      |-> tdr_avg_cycles_o == (tdr_avg_code_o == 3'h7 ? 7'h0 : 7'h1 << tdr_avg_code_o);
  endproperty
  a_cyc: assert property (p_cyc) else $error("cycle count wrong");
endmodule // pmc_regbank_chk
bind pmc_regbank pmc_regbank_chk pmc_regbank_chk_inst (.*);
`default_nettype wire

// ===== verif/pmc_regbank_tb_top.sv
// Self-checking bench for the control register bank.
// Drives APB and the diagnostic inputs itself; no other model.
`timescale 1ns/1ns
`default_nettype none
module pmc_regbank_tb_top;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic e;} pmc_row_t;
  logic ref_clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, er;
  logic cable_length_valid_i = 0, transmit_pair_bypass_i = 0;
  logic [7:0] cable_length_result_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic pready_o, pslverr_o, phase_busy_o, phase_step_o;
  logic [3:0] tx_clock_phase_o;
  logic [2:0] power_backoff_level_o, cable_length_avg_o;
  logic [6:0] tdr_avg_cycles_o;
  int bad_count = 0, cmp_count = 0, n, seen, steps;
  int pexp[4] = '{2, 9, 5, 10};
  int pstep[4] = '{2, 7, 4, 5};
  logic [31:0] pv[4] = '{32'hfff2, 32'h19, 32'h1f, 32'h1a};
  // Read rows expect data; register writes keep regulator bits 14 to 4 zero.
  pmc_row_t rows[14] = '{'{0, 12'h108, 0, 0}, '{0, 12'h2b8, 32'h8020, 0},
    '{0, 12'h554, 32'h1, 0}, '{0, 12'h5c0, 32'he00, 0}, '{0, 12'h340, 0, 0},
    '{1, 12'h340, 32'h800a, 0}, '{0, 12'h340, 32'ha, 0},
    '{1, 12'h554, 32'hfffff00e, 0}, '{0, 12'h554, 32'h6, 0},
    '{1, 12'h5c0, 32'h7f00, 0}, '{0, 12'h5c0, 32'h6f00, 0},
    '{1, 12'h5c0, 32'h4d00, 0}, '{0, 12'h5c0, 32'h4d00, 0}, '{0, 12'h004, 0, 1}};
  pmc_regbank pmc_regbank_inst (.*, .phase_step_up_o(), .regulator_power_down_o(),
    .regulator_control_o(), .cable_length_start_o(), .tdr_cross_disable_o(),
    .transmit_pair_bypass_o(), .tdr_avg_code_o());
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    if (k == 20) begin
      bad_count++;
      final_report();
    end
  endtask
  initial forever #20 ref_clk_i = ~ref_clk_i;
  initial begin
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 0;
    chk("avg cycles", tdr_avg_cycles_o, 64);
    chk("length avg", cable_length_avg_o, 1);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("error flag", er, rows[i].e);
      if (!rows[i].w) chk("row read", rd, rows[i].d);
    end
    $display("row table done");
    for (int c = 0; c < 4; c++) begin
      apb(1, 12'h2b8, c << 6);
      repeat (2) @(posedge ref_clk_i);
      chk("level", power_backoff_level_o, c);
      apb(0, 12'h2b8, 0);
      chk("backoff", rd, 32'h8020 | (c << 6));
    end
    $display("backoff done");
    foreach (pv[i]) begin
      apb(1, 12'h108, pv[i]);
      n = 0;
      seen = 0;
      steps = 0;
      while (!(seen && phase_busy_o === 1'b0) && n < 40) begin
        @(posedge ref_clk_i);
        n++;
        seen |= phase_busy_o;
        steps += phase_step_o;
      end
      if (n == 40) begin
        bad_count++;
        final_report();
      end
      chk("steps", steps, pstep[i]);
      chk("phase out", tx_clock_phase_o, pexp[i]);
      apb(0, 12'h108, 0);
      chk("phase read", rd, pexp[i]);
    end
    apb(1, 12'h108, 32'h3);
    apb(0, 12'h108, 0);
    chk("no shift", rd, 32'ha);
    $display("phase done");
    transmit_pair_bypass_i <= 1;
    cable_length_result_i <= 8'ha5;
    cable_length_valid_i <= 1;
    @(posedge ref_clk_i);
    cable_length_valid_i <= 0;
    apb(0, 12'h554, 0);
    chk("result", rd, 32'h1a56);
    $display("result done");
    transmit_pair_bypass_i <= 0;
    reset_i <= 1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 0;
    chk("phase reset", tx_clock_phase_o, 0);
    chk("level reset", power_backoff_level_o, 0);
    chk("avg reset", cable_length_avg_o, 1);
    chk("cycles reset", tdr_avg_cycles_o, 64);
    apb(0, 12'h5c0, 0);
    chk("diag reset", rd, 32'he00);
    $display("reset done");
    final_report();
  end
endmodule // pmc_regbank_tb_top
`default_nettype wire
